// *** rtl/plsp_pkg.sv ***
package plsp_pkg;

  // Serial word layout
  localparam int PLSP_DATA_W = 17;
  localparam int PLSP_ADDR_W = 4;
  localparam int PLSP_WORD_W = PLSP_DATA_W + PLSP_ADDR_W;

  // Latch addresses
  localparam logic [PLSP_ADDR_W-1:0] PLSP_ADDR_TEST = 4'h0;
  localparam logic [PLSP_ADDR_W-1:0] PLSP_ADDR_CTRL = 4'h1;
  localparam logic [PLSP_ADDR_W-1:0] PLSP_ADDR_MAIN = 4'h4;
  localparam logic [PLSP_ADDR_W-1:0] PLSP_ADDR_REF = 4'h5;

  // Ratio field widths
  localparam int PLSP_MAIN_W = 17;
  localparam int PLSP_REF_W = 11;

  // Control latch field positions within the data field
  localparam int PLSP_LDE_BIT = 12;
  localparam int PLSP_PUMP_LSB = 8;
  localparam int PLSP_PUMP_W = 4;
  localparam int PLSP_SOFT_BIT = 4;

  // Reset values and accepted ratio ranges
  localparam logic [PLSP_MAIN_W-1:0] PLSP_MAIN_RST = 17'h00200;
  localparam logic [PLSP_REF_W-1:0] PLSP_REF_RST = 11'h008;
  localparam logic [PLSP_MAIN_W-1:0] PLSP_MAIN_MIN = 17'h00200;
  localparam logic [PLSP_MAIN_W-1:0] PLSP_MAIN_MAX = 17'h1FFFF;
  localparam logic [PLSP_REF_W-1:0] PLSP_REF_MIN = 11'h008;
  localparam logic [PLSP_REF_W-1:0] PLSP_REF_MAX = 11'h7FF;
  localparam logic [PLSP_DATA_W-1:0] PLSP_TEST_RST = 17'h00000;

  // Timing
  localparam int PLSP_REF_CLK_MHZ = 200;
  localparam int PLSP_OOL_THRESH_NS = 25;
  localparam int PLSP_ERR_W = 8;
  localparam logic [PLSP_ERR_W-1:0] PLSP_OOL_CYC =
    PLSP_ERR_W'((PLSP_OOL_THRESH_NS * PLSP_REF_CLK_MHZ) / 1000);

  // Shifted word: first bit in ends up in data MSB
  typedef struct packed {
    logic [PLSP_DATA_W-1:0] data;
    logic [PLSP_ADDR_W-1:0] addr;
  } plsp_word_t;

  // Control latch contents
  typedef struct packed {
    logic soft_power_up_bit;
    logic lock_detector_enable;
    logic [PLSP_PUMP_W-1:0] pump_current_select;
  } plsp_ctrl_t;

endpackage

// *** rtl/plsp_shift_in.sv ***
`timescale 1ns/1ps
`default_nettype none
module plsp_shift_in
  import plsp_pkg::*;
(
  // Programming bus, link clock domain
  input wire logic prog_clk,
  input wire logic prog_data,
  input wire logic prog_enable_n,
  // Last word shifted in
  output var plsp_word_t word
);

  typedef struct packed {
    logic [PLSP_WORD_W-1:0] sr;
  } plsp_sin_state_t;

  plsp_sin_state_t st;
  plsp_sin_state_t next_st;

  // Shift only while enable is low; older bits fall off the top
  always_comb
  begin
    next_st = st;
    if (!prog_enable_n)
    begin
      next_st.sr = {st.sr[PLSP_WORD_W-2:0], prog_data}; // R11
    end
  end

  // Bus clock stops between frames, so no reset here
  always_ff @(posedge prog_clk)
  begin
    st <= next_st;
  end

  assign word = plsp_word_t'(st.sr); // R04

  // Clock edges with enable high leave the register alone
  property p_word_frozen;
    @(posedge prog_clk) prog_enable_n |=> $stable(st.sr);
  endproperty
  a_word_frozen: assert property (p_word_frozen) else $error("word moved with enable high"); // R11

endmodule // plsp_shift_in
`default_nettype wire

// *** rtl/plsp_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module plsp_divider
  import plsp_pkg::*;
#(
  parameter int W = 17
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Count control
  input wire logic run,
  input wire logic in_edge,
  input wire logic [W-1:0] ratio,
  // One pulse per ratio input edges
  output logic tick
);

  typedef struct packed {
    logic [W-1:0] count;
    logic tick;
  } plsp_div_state_t;

  plsp_div_state_t st;
  plsp_div_state_t next_st;
  logic [W-1:0] last;

  assign last = ratio - {{(W-1){1'b0}}, 1'b1};

  // Counter compares against ratio minus one on every input edge while run is high
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run)
    begin
      next_st.count = '0;
    end
    else if (in_edge)
    begin
      if (st.count >= last)
      begin
        next_st.count = '0;
        next_st.tick = 1'b1;
      end
      else
      begin
        next_st.count = st.count + {{(W-1){1'b0}}, 1'b1};
      end
    end
    if (rst)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    st <= next_st;
  end

  assign tick = st.tick;

  // Terminal count yields exactly one tick
  property p_div_term;
    @(posedge ref_clk) disable iff (rst)
    (run && in_edge && st.count == last) |=> (tick && st.count == '0);
  endproperty
  a_div_term: assert property (p_div_term) else $error("divider missed terminal tick"); // R09

  // Count below terminal never steps past it
  property p_div_range;
    @(posedge ref_clk) disable iff (rst)
    (run && st.count < last) |=> (st.count <= $past(last));
  endproperty
  a_div_range: assert property (p_div_range) else $error("divider count out of range"); // R10

endmodule // plsp_divider
`default_nettype wire

// *** rtl/plsp_latch_bank.sv ***
// Functional notes
// [R01] Host writes only zeros to the test latch, or leaves it alone.
// [R02] Control latch holds the software power-up bit for the power decision.
// [R03] Lock detector enable bit set to 1 enables the detector, 0 disables.
// [R04] Main ratio bit 16 is its MSB and the first bit shifted.
// [R05] Reference ratio bit 10 is its MSB; higher data bits are ignored.
// [R06] Enabled detector flags out-of-lock when phase error exceeds about 25 ns.
// [R07] Host holds enable high at least 4000 ns after each transfer.
// [R08] Shorter enable-high time only with fast enough divider input frequencies.
// [R09] Main ratios 512 to 131071 inclusive are accepted.
// [R10] Reference ratios 8 to 2047 inclusive are accepted.
// [R11] Clock ignored while enable high; last 21 bits kept, no count check.
// [R12] Synthesizer on only when hard input and soft bit both active.
// [R13] Disabled detector keeps the lock output in its high state.
`timescale 1ns/1ps
`default_nettype none
module plsp_latch_bank
  import plsp_pkg::*;
(
  // System clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial programming bus
  input wire logic prog_clk,
  input wire logic prog_data,
  input wire logic prog_enable_n,
  // Power control pins
  input wire logic hard_power_on_input,
  input wire logic power_on_polarity_select,
  // Divider inputs
  input wire logic rf_divider_input,
  input wire logic crystal_input_pos,
  input wire logic crystal_input_neg,
  // Synthesizer status and control
  output logic synth_on,
  output logic [PLSP_PUMP_W-1:0] pump_current_select,
  output logic pump_sink,
  output logic pump_source,
  output logic test_mode_active,
  // Open-drain lock pin
  output logic lock_o,
  output logic lock_oe
);

  typedef struct packed {
    logic [1:0] en_sync;
    logic [1:0] rf_sync;
    logic [1:0] xp_sync;
    logic [1:0] xn_sync;
    logic [1:0] pon_sync;
    logic [1:0] pol_sync;
    logic en_prev;
    logic rf_prev;
    logic xt_prev;
    logic [PLSP_MAIN_W-1:0] main_ratio;
    logic [PLSP_REF_W-1:0] ref_ratio;
    plsp_ctrl_t ctrl;
    logic [PLSP_DATA_W-1:0] test_latch;
    logic synth_on;
    logic wait_main;
    logic wait_ref;
    logic [PLSP_ERR_W-1:0] err_cnt;
    logic out_of_lock;
    logic lock_oe;
  } plsp_bank_state_t;

  plsp_bank_state_t st;
  plsp_bank_state_t next_st;
  plsp_word_t word;
  logic xt_level;
  logic load;
  logic rf_edge;
  logic xt_edge;
  logic main_tick;
  logic ref_tick;
  logic finish_main;
  logic finish_ref;

  // Link-side shift register on the bus clock
  plsp_shift_in u_shift (
    .prog_clk(prog_clk),
    .prog_data(prog_data),
    .prog_enable_n(prog_enable_n),
    .word(word)
  );

  // Main divider on the RF input
  plsp_divider #(.W(PLSP_MAIN_W)) u_main_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(st.synth_on),
    .in_edge(rf_edge),
    .ratio(st.main_ratio),
    .tick(main_tick)
  );

  // Reference divider on the crystal input
  plsp_divider #(.W(PLSP_REF_W)) u_ref_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(st.synth_on),
    .in_edge(xt_edge),
    .ratio(st.ref_ratio),
    .tick(ref_tick)
  );

  // Crystal pair reduced to one level after each pin is synchronised
  assign xt_level = st.xp_sync[1] & ~st.xn_sync[1];

  // Edge detects read only the second synchroniser stage
  assign load = st.en_sync[1] & ~st.en_prev;
  assign rf_edge = st.rf_sync[1] & ~st.rf_prev;
  assign xt_edge = xt_level & ~st.xt_prev;

  // Second edge of a pair closes a phase measurement
  assign finish_main = main_tick & ~ref_tick & st.wait_main;
  assign finish_ref = ref_tick & ~main_tick & st.wait_ref;

  always_comb
  begin
    next_st = st;
    // Synchronisers and edge history
    next_st.en_sync = {st.en_sync[0], prog_enable_n};
    next_st.rf_sync = {st.rf_sync[0], rf_divider_input};
    next_st.xp_sync = {st.xp_sync[0], crystal_input_pos};
    next_st.xn_sync = {st.xn_sync[0], crystal_input_neg};
    next_st.pon_sync = {st.pon_sync[0], hard_power_on_input};
    next_st.pol_sync = {st.pol_sync[0], power_on_polarity_select};
    next_st.en_prev = st.en_sync[1];
    next_st.rf_prev = st.rf_sync[1];
    next_st.xt_prev = xt_level;

    // Load on enable rising; word is static while bus clock is idle
    if (load) // R11
    begin
      case (word.addr)
        PLSP_ADDR_MAIN:
        begin
          next_st.main_ratio = word.data; // R04 R09
        end
        PLSP_ADDR_REF:
        begin
          next_st.ref_ratio = word.data[PLSP_REF_W-1:0]; // R05 R10
        end
        PLSP_ADDR_CTRL:
        begin
          next_st.ctrl.soft_power_up_bit = word.data[PLSP_SOFT_BIT]; // R02
          next_st.ctrl.lock_detector_enable = word.data[PLSP_LDE_BIT]; // R03
          next_st.ctrl.pump_current_select =
            word.data[PLSP_PUMP_LSB +: PLSP_PUMP_W];
        end
        PLSP_ADDR_TEST:
        begin
          next_st.test_latch = word.data; // R01
        end
        default:
        begin
          next_st.test_latch = st.test_latch;
        end
      endcase
    end

    // Both power-on terms must sit at the selected active level
    next_st.synth_on = (st.pon_sync[1] == st.pol_sync[1]) &&
      (st.ctrl.soft_power_up_bit == st.pol_sync[1]); // R12

    // Phase error measurement between divider edges
    if (!st.synth_on)
    begin
      next_st.wait_main = 1'b0;
      next_st.wait_ref = 1'b0;
      next_st.err_cnt = '0;
      next_st.out_of_lock = 1'b0;
    end
    else if (main_tick && ref_tick)
    begin
      next_st.wait_main = 1'b0;
      next_st.wait_ref = 1'b0;
      next_st.err_cnt = '0;
      next_st.out_of_lock = 1'b0;
    end
    else if (finish_main || finish_ref)
    begin
      next_st.wait_main = 1'b0;
      next_st.wait_ref = 1'b0;
      next_st.out_of_lock = (st.err_cnt >= PLSP_OOL_CYC); // R06
    end
    else if (main_tick && !st.wait_ref)
    begin
      next_st.wait_ref = 1'b1;
      next_st.err_cnt = '0;
    end
    else if (ref_tick && !st.wait_main)
    begin
      next_st.wait_main = 1'b1;
      next_st.err_cnt = '0;
    end
    else if ((st.wait_main || st.wait_ref) && (st.err_cnt != '1))
    begin
      next_st.err_cnt = st.err_cnt + {{(PLSP_ERR_W-1){1'b0}}, 1'b1};
    end

    // Pull the lock pin low only when enabled and out of lock
    next_st.lock_oe = st.ctrl.lock_detector_enable & st.out_of_lock; // R03 R13

    if (rst)
    begin
      next_st = '0;
      next_st.en_sync = 2'h3;
      next_st.en_prev = 1'b1;
      next_st.main_ratio = PLSP_MAIN_RST;
      next_st.ref_ratio = PLSP_REF_RST;
      next_st.test_latch = PLSP_TEST_RST;
    end
  end

  // Single state register
  always_ff @(posedge ref_clk)
  begin
    st <= next_st;
  end

  // Outputs straight from state
  assign synth_on = st.synth_on;
  assign pump_current_select = st.ctrl.pump_current_select;
  assign pump_sink = st.wait_ref;
  assign pump_source = st.wait_main;
  assign test_mode_active = |st.test_latch;
  assign lock_o = 1'b0;
  assign lock_oe = st.lock_oe;

  default clocking plsp_cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Control load carries the soft power bit
  property p_soft_load;
    (load && word.addr == PLSP_ADDR_CTRL) |=>
      (st.ctrl.soft_power_up_bit == $past(word.data[PLSP_SOFT_BIT]));
  endproperty
  a_soft_load: assert property (p_soft_load) else $error("soft power bit not loaded"); // R02

  // Detector enable and out-of-lock pull the pin low next cycle
  property p_lock_drive;
    (st.ctrl.lock_detector_enable && st.out_of_lock) |=> lock_oe;
  endproperty
  a_lock_drive: assert property (p_lock_drive) else $error("lock pin not pulled low"); // R03

  // Main ratio takes the whole data field, first bit as MSB
  property p_main_load;
    (load && word.addr == PLSP_ADDR_MAIN) |=> (st.main_ratio == $past(word.data));
  endproperty
  a_main_load: assert property (p_main_load) else $error("main ratio not loaded"); // R04

  // Reference ratio keeps only the low eleven data bits
  property p_ref_load;
    (load && word.addr == PLSP_ADDR_REF) |=>
      (st.ref_ratio == $past(word.data[PLSP_REF_W-1:0]));
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("reference ratio not loaded"); // R05

  // Late second edge flags out-of-lock, then the pin follows
  property p_ool_flag;
    ((finish_main || finish_ref) && st.err_cnt >= PLSP_OOL_CYC &&
      st.ctrl.lock_detector_enable && st.synth_on) |=> st.out_of_lock ##1
      (lock_oe || !$past(st.ctrl.lock_detector_enable));
  endproperty
  a_ool_flag: assert property (p_ool_flag) else $error("out-of-lock not reported"); // R06

  // Any in-range main ratio load leaves the stored ratio at or above the minimum
  property p_main_range;
    (load && word.addr == PLSP_ADDR_MAIN && word.data >= PLSP_MAIN_MIN &&
      word.data <= PLSP_MAIN_MAX) |=> (st.main_ratio >= PLSP_MAIN_MIN);
  endproperty
  a_main_range: assert property (p_main_range) else $error("main ratio range rejected"); // R09

  // Any reference load at or above the minimum leaves the stored ratio within the accepted range
  property p_ref_range;
    (load && word.addr == PLSP_ADDR_REF &&
      word.data[PLSP_REF_W-1:0] >= PLSP_REF_MIN) |=>
      (st.ref_ratio >= PLSP_REF_MIN && st.ref_ratio <= PLSP_REF_MAX);
  endproperty
  a_ref_range: assert property (p_ref_range) else $error("reference ratio range rejected"); // R10

  // Only one pump direction at a time
  property p_pump_excl;
    !(pump_sink && pump_source);
  endproperty
  a_pump_excl: assert property (p_pump_excl) else $error("both pump directions active"); // R06

  // Power off clears any open phase measurement
  property p_off_clear;
    !synth_on |=> (!pump_sink && !pump_source);
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("power off left a pump active"); // R12

  // Power state follows both power terms
  property p_power;
    ((st.pon_sync[1] == st.pol_sync[1]) &&
      (st.ctrl.soft_power_up_bit == st.pol_sync[1])) ##1 1'b1 |-> synth_on;
  endproperty
  a_power: assert property (p_power) else $error("synthesizer not powered"); // R12

  // Detector disabled for two cycles never pulls the pin low
  property p_lock_idle;
    (!st.ctrl.lock_detector_enable) [*2] |-> !lock_oe;
  endproperty
  a_lock_idle: assert property (p_lock_idle) else $error("lock pin low while disabled"); // R13

endmodule // plsp_latch_bank
`default_nettype wire

// *** testbench/plsp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module plsp_host
(
  // Bus lines to the device
  output logic prog_clk,
  output logic prog_data,
  output logic prog_enable_n
);
  // Idle bus: clock parked, enable inactive
  initial
  begin
    prog_clk = 1'b0;
    prog_data = 1'b0;
    prog_enable_n = 1'b1;
  end

  // Shift n bits first-MSB; keep_hi leaves enable inactive
  task automatic send(input logic [31:0] bits, input int n, input bit keep_hi);
    prog_enable_n = keep_hi;
    #62.5;
    for (int i = n - 1; i >= 0; i--)
    begin
      prog_data = bits[i];
      #62.5 prog_clk = 1'b1;
      #62.5 prog_clk = 1'b0;
    end
    #22.5 prog_enable_n = 1'b1;
    prog_data = ~prog_data; // Released line shows no stale value
    #4000;
  endtask
endmodule // plsp_host
`default_nettype wire

// *** testbench/test_pll_serial_program_latches.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_pll_serial_program_latches
  import plsp_pkg::*;
;
  logic ref_clk, rst, prog_clk, prog_data, prog_enable_n;
  logic hard_power_on_input, power_on_polarity_select;
  logic rf_divider_input, crystal_input_pos, crystal_input_neg;
  logic synth_on, pump_sink, pump_source, test_mode_active, lock_o, lock_oe;
  logic [PLSP_PUMP_W-1:0] pump_current_select;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  // Device under test
  plsp_latch_bank plsp_latch_bank_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .prog_clk(prog_clk),
    .prog_data(prog_data),
    .prog_enable_n(prog_enable_n),
    .hard_power_on_input(hard_power_on_input),
    .power_on_polarity_select(power_on_polarity_select),
    .rf_divider_input(rf_divider_input),
    .crystal_input_pos(crystal_input_pos),
    .crystal_input_neg(crystal_input_neg),
    .synth_on(synth_on),
    .pump_current_select(pump_current_select),
    .pump_sink(pump_sink),
    .pump_source(pump_source),
    .test_mode_active(test_mode_active),
    .lock_o(lock_o),
    .lock_oe(lock_oe)
  );

  // Host controller on the programming bus
  plsp_host plsp_host_i (
    .prog_clk(prog_clk),
    .prog_data(prog_data),
    .prog_enable_n(prog_enable_n)
  );

  // System clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic results;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  function automatic logic [31:0] wd(input logic [16:0] d, input logic [3:0] a);
    return {11'h000, d, a};
  endfunction

  function automatic logic [16:0] ctl(input logic lde, input logic [3:0] pc, input logic sb);
    return 17'(lde) << PLSP_LDE_BIT | 17'(pc) << PLSP_PUMP_LSB | 17'(sb) << PLSP_SOFT_BIT;
  endfunction

  // One whole frame, then back on the falling edge
  task automatic frame(input logic [31:0] b, input int n);
    plsp_host_i.send(b, n, 1'b0);
    cyc(2);
  endtask

  task automatic t_reset;
    cyc(10);
    chk(4'(synth_on), 4'h1);
    chk(pump_current_select, 4'h0);
    chk(4'({test_mode_active, lock_oe, lock_o}), 4'h0);
  endtask

  task automatic t_ctrl;
    frame(32'h01400000 | wd(ctl(1'b0, 4'hA, 1'b1), PLSP_ADDR_CTRL), 25);
    chk(pump_current_select, 4'hA);
    chk(4'(synth_on), 4'h0);
    power_on_polarity_select = 1'b1;
    hard_power_on_input = 1'b1;
    cyc(8);
    chk(4'(synth_on), 4'h1);
    hard_power_on_input = 1'b0;
    cyc(8);
    chk(4'(synth_on), 4'h0);
    power_on_polarity_select = 1'b0;
    frame(wd(ctl(1'b0, 4'h5, 1'b0), PLSP_ADDR_CTRL), 21);
    chk(4'(synth_on), 4'h1);
    chk(pump_current_select, 4'h5);
  endtask

  // Unknown address, then clocks with enable high, then an empty frame
  task automatic t_ignore;
    frame(wd(ctl(1'b0, 4'h3, 1'b0), 4'h2), 21);
    chk(pump_current_select, 4'h5);
    plsp_host_i.send(wd(ctl(1'b0, 4'hF, 1'b0), PLSP_ADDR_CTRL), 21, 1'b1);
    frame(32'h00000000, 0);
    chk(pump_current_select, 4'h5);
    frame(wd(PLSP_TEST_RST, PLSP_ADDR_TEST), 21);
    chk(4'(test_mode_active), 4'h0);
  endtask

  // Main edge first with reference edge far behind, then reference edge first with main edge far behind
  task automatic t_lock;
    int n;
    frame(wd(17'h00200, PLSP_ADDR_MAIN), 21);
    frame(wd(17'h1F808, PLSP_ADDR_REF), 21);
    frame(wd(ctl(1'b1, 4'h5, 1'b0), PLSP_ADDR_CTRL), 21);
    n = 0;
    while (pump_sink !== 1'b1 && n < 2400)
    begin
      rf_divider_input = ~rf_divider_input;
      cyc(2);
      n++;
    end
    chk(4'({pump_sink, pump_source}), 4'h2);
    n = 0;
    while (pump_sink === 1'b1 && n < 60)
    begin
      crystal_input_pos = ~crystal_input_pos;
      cyc(2);
      n++;
    end
    chk(4'(n > 2 && n < 60), 4'h1);
    cyc(2);
    chk(4'({lock_oe, lock_o}), 4'h2);
    n = 0;
    while (pump_source !== 1'b1 && n < 60)
    begin
      crystal_input_pos = ~crystal_input_pos;
      cyc(2);
      n++;
    end
    chk(4'({pump_sink, pump_source}), 4'h1);
    n = 0;
    while (pump_source === 1'b1 && n < 2400)
    begin
      rf_divider_input = ~rf_divider_input;
      cyc(2);
      n++;
    end
    chk(4'(n > 2 && n < 2400), 4'h1);
    cyc(2);
    chk(4'({lock_oe, pump_source}), 4'h2);
    frame(wd(ctl(1'b0, 4'h5, 1'b0), PLSP_ADDR_CTRL), 21);
    chk(4'(lock_oe), 4'h0);
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    hard_power_on_input = 1'b0;
    power_on_polarity_select = 1'b0;
    rf_divider_input = 1'b0;
    crystal_input_pos = 1'b0;
    crystal_input_neg = 1'b0;
    cyc(6);
    rst = 1'b0;
    t_reset();
    t_ctrl();
    t_ignore();
    t_lock();
    results();
  end
endmodule // test_pll_serial_program_latches
`default_nettype wire
